/* verilog/arcr_timer.sv */
// Purpose: capture, reload and flag logic of a 16-bit auto-reload down-counter timer
// Assumes: single 40 MHz sys_clk, capture pins asynchronous to it, wishbone slave
// Notes:   compare/mask and pwm logic sit outside; they report through two event inputs
// Contract
// - reload source select picks reload trigger
// - input-a restart: each edge while no input-a error is set reloads, flags, restarts
// - input-a flag set at reload sets error
// - input-b capture while counting; error blocks captures
// - captures resume after both b flags cleared
// - coincident capture happens before reload
// - input-b restart: capture if allowed, then reload
// - input-b restart: input-a only touches flags
// - input-b restart: first input-b event captures zero counter
// - software restart: run reloads, input-b strobes
// - run without reload enable counts freely
// - free run: input-a captures into reload register
// - free run: input-b captures into capture register
// - flags latch whatever the enables; interrupt ors five pairs
// - prescale select: off, div1, div4, div16
// - reset forces prescaler disabled
// - reload enable chooses reload source or target
// - run low holds counter at zero
// - overflow flag sticky, software clears only
// - overflow pin set/clear or toggle mode
// - error flag blocks flags, captures and input-a restarts, not input-b restarts; clear only
// - input-a polarity selects falling or rising
// - input-b polarity selects falling or rising
// - overflow reloads full count or reload value
`timescale 1ns/1ps
module arcr_timer #(
  parameter int ADR_W = 10
) (
  input  wire logic              sys_clk,
  input  wire logic              reset,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              capture_input_a,
  input  wire logic              capture_input_b,
  input  wire logic              match_event,
  input  wire logic              masked_zero_event,
  output logic                   timer_irq,
  output logic                   overflow_output_pin
);

  ////////////////////////////////////////////////////////////////////////////
  // elaboration check: index field needs bits 9:2
  if (ADR_W < 10) begin : g_bad_adr
    $error("arcr_timer: ADR_W must be at least 10");
  end

  ////////////////////////////////////////////////////////////////////////////
  // whole state of the block
  typedef struct packed {
    logic [2:0]           sync_a;
    logic [2:0]           sync_b;
    logic [3:0]           psc_cnt;
    arcr_pkg::arcr_state_t st;
    logic [15:0]          down_counter;
    logic [15:0]          reload_capture_register;
    logic [15:0]          capture_value_register;
    arcr_pkg::arcr_psc_t  prescale_select;
    logic                 reload_enable;
    logic                 run_reset_bit;
    logic                 overflow_irq_enable;
    logic                 overflow_flag;
    logic                 overflow_output_mode;
    logic                 input_a_error_flag;
    logic                 input_b_error_flag;
    logic                 input_a_irq_enable;
    logic                 input_a_event_flag;
    logic                 input_a_edge_polarity;
    arcr_pkg::arcr_sel_t  reload_source_select;
    logic                 input_b_edge_polarity;
    logic                 input_b_irq_enable;
    logic                 input_b_event_flag;
    logic                 match_irq_enable;
    logic                 match_flag;
    logic                 masked_zero_irq_enable;
    logic                 masked_zero_flag;
    logic                 ack;
    logic [31:0]          rdata;
    logic                 irq;
    logic                 ovf_pin;
  } arcr_state_s_t;

  arcr_state_s_t q;
  arcr_state_s_t next_q;

  ////////////////////////////////////////////////////////////////////////////
  // combinational next state
  always_comb begin
    logic       access;
    logic       wr;
    logic [7:0] idx;
    logic       hit_rp;
    logic       hit_cs;
    logic       hit_bc;
    logic       hit_rl;
    logic [7:0] wd;
    logic       tick;
    logic       ev_a;
    logic       ev_b;
    logic       acc_a;
    logic       acc_b;
    logic       ovf;
    logic       b_may_capture;
    next_q = q;
    access = wb_cyc_i && wb_stb_i && !q.ack;
    wr     = access && wb_we_i && wb_sel_i[0];
    idx    = wb_adr_i[9:2];
    wd     = wb_dat_i[7:0];
    hit_rp = 1'b0;
    hit_cs = 1'b0;
    hit_bc = 1'b0;
    hit_rl = 1'b0;
    tick   = 1'b0;
    ovf    = 1'b0;

    // bus handshake: one wait state, ack held a single cycle
    next_q.ack = access;

    // address decode; anything above the index field is unmapped
    if (wb_adr_i[ADR_W-1:2] != (ADR_W-2)'(idx)) begin
      next_q.rdata = 32'h0000_0000;
    end else if (idx == arcr_pkg::IDX_RUNPSC) begin
      hit_rp = 1'b1;
      next_q.rdata = {24'h00_0000, q.prescale_select, q.reload_enable, q.run_reset_bit,
                      q.overflow_irq_enable, q.overflow_flag, q.overflow_output_mode, 1'b0};
    end else if (idx == arcr_pkg::IDX_CAPSTAT) begin
      hit_cs = 1'b1;
      next_q.rdata = {24'h00_0000, 1'b0, q.input_a_error_flag, q.input_b_error_flag,
                      q.input_a_irq_enable, q.input_a_event_flag, q.input_a_edge_polarity,
                      q.reload_source_select};
    end else if (idx == arcr_pkg::IDX_BCTRL) begin
      hit_bc = 1'b1;
      next_q.rdata = {24'h00_0000, q.input_b_edge_polarity, q.input_b_irq_enable,
                      q.input_b_event_flag, q.match_irq_enable, q.match_flag,
                      q.masked_zero_irq_enable, q.masked_zero_flag, 1'b0};
    end else if (idx == arcr_pkg::IDX_RELOAD) begin
      hit_rl = 1'b1;
      next_q.rdata = {16'h0000, q.reload_capture_register};
    end else if (idx == arcr_pkg::IDX_CAPTURE) begin
      next_q.rdata = {16'h0000, q.capture_value_register};
    end else if (idx == arcr_pkg::IDX_COUNTER) begin
      next_q.rdata = {16'h0000, q.down_counter};
    end else begin
      next_q.rdata = 32'h0000_0000;
    end
    if (!access || wb_we_i) begin
      next_q.rdata = 32'h0000_0000; // reads only answer a read
    end

    // software writes; flag bits can only be cleared by writing zero
    if (wr && hit_rp) begin
      next_q.prescale_select      = arcr_pkg::arcr_psc_t'(wd[arcr_pkg::RP_PSC_HI:
                                                            arcr_pkg::RP_PSC_LO]);
      next_q.reload_enable        = wd[arcr_pkg::RP_RELOAD];
      next_q.run_reset_bit        = wd[arcr_pkg::RP_RUN];
      next_q.overflow_irq_enable  = wd[arcr_pkg::RP_OVF_IEN];
      next_q.overflow_flag        = q.overflow_flag && wd[arcr_pkg::RP_OVF_FLG];
      next_q.overflow_output_mode = wd[arcr_pkg::RP_OVF_MD];
    end
    if (wr && hit_cs) begin
      next_q.input_a_error_flag    = q.input_a_error_flag && wd[arcr_pkg::CS_A_ERR];
      next_q.input_b_error_flag    = q.input_b_error_flag && wd[arcr_pkg::CS_B_ERR];
      next_q.input_a_irq_enable    = wd[arcr_pkg::CS_A_IEN];
      next_q.input_a_event_flag    = q.input_a_event_flag && wd[arcr_pkg::CS_A_FLG];
      next_q.input_a_edge_polarity = wd[arcr_pkg::CS_A_POL];
      next_q.reload_source_select  = arcr_pkg::arcr_sel_t'(wd[arcr_pkg::CS_SEL_HI:
                                                              arcr_pkg::CS_SEL_LO]);
    end
    if (wr && hit_bc) begin
      next_q.input_b_edge_polarity  = wd[arcr_pkg::BC_B_POL];
      next_q.input_b_irq_enable     = wd[arcr_pkg::BC_B_IEN];
      next_q.input_b_event_flag     = q.input_b_event_flag && wd[arcr_pkg::BC_B_FLG];
      next_q.match_irq_enable       = wd[arcr_pkg::BC_M_IEN];
      next_q.match_flag             = q.match_flag && wd[arcr_pkg::BC_M_FLG];
      next_q.masked_zero_irq_enable = wd[arcr_pkg::BC_Z_IEN];
      next_q.masked_zero_flag       = q.masked_zero_flag && wd[arcr_pkg::BC_Z_FLG];
    end
    // the reload value is writable only while it is a reload source
    if (wr && hit_rl && q.reload_enable && wb_sel_i[1]) begin
      next_q.reload_capture_register = wb_dat_i[15:0];
    end

    // three-stage synchronisers; only stages two and three are compared
    next_q.sync_a = {q.sync_a[1:0], capture_input_a};
    next_q.sync_b = {q.sync_b[1:0], capture_input_b};
    // events exist only while running, which gates the synchronised edges
    ev_a = q.run_reset_bit && (q.sync_a[1] != q.sync_a[2])
           && (q.sync_a[1] == q.input_a_edge_polarity);
    ev_b = q.run_reset_bit && (q.sync_b[1] != q.sync_b[2])
           && (q.sync_b[1] == q.input_b_edge_polarity);
    acc_a = ev_a && !q.input_a_error_flag;
    acc_b = ev_b && !q.input_b_error_flag;

    // prescaler; the off setting also clears the divider
    case (q.prescale_select)
      arcr_pkg::ARCR_PSC_OFF: begin
        next_q.psc_cnt = 4'h0;
      end
      arcr_pkg::ARCR_PSC_DIV1: begin
        tick = 1'b1;
        next_q.psc_cnt = 4'h0;
      end
      arcr_pkg::ARCR_PSC_DIV4: begin
        tick = (q.psc_cnt[1:0] == arcr_pkg::PSC_DIV4_LAST[1:0]);
        next_q.psc_cnt = {2'b00, q.psc_cnt[1:0] + 2'b01};
      end
      default: begin
        tick = (q.psc_cnt == arcr_pkg::PSC_DIV16_LAST);
        next_q.psc_cnt = q.psc_cnt + 4'h1;
      end
    endcase

    // in input-a restart mode input-b only captures once counting
    b_may_capture = !(q.reload_enable && q.reload_source_select == arcr_pkg::ARCR_SEL_A)
                    || (q.st == arcr_pkg::ARCR_ST_COUNT);

    // input-a flags; in input-b restart mode this is all input-a does
    if (acc_a) begin
      if (q.input_a_event_flag) begin
        next_q.input_a_error_flag = 1'b1;
      end else begin
        next_q.input_a_event_flag = 1'b1;
        if (!q.reload_enable) begin
          next_q.reload_capture_register = q.down_counter;
        end
      end
    end

    // input-b flags and capture; in input-a restart mode only once counting
    if (acc_b && b_may_capture) begin
      if (q.input_b_event_flag) begin
        next_q.input_b_error_flag = 1'b1;
      end else begin
        next_q.input_b_event_flag = 1'b1;
        // capture takes the pre-reload count, so it precedes any reload
        next_q.capture_value_register = q.down_counter;
      end
    end

    // counter state machine
    if (!q.run_reset_bit) begin
      next_q.down_counter = arcr_pkg::CNT_ZERO;
      next_q.st = arcr_pkg::ARCR_ST_HOLD;
    end else begin
      case (q.st)
        arcr_pkg::ARCR_ST_HOLD: begin
          if (!q.reload_enable) begin
            next_q.st = arcr_pkg::ARCR_ST_COUNT;
          end else if (q.reload_source_select == arcr_pkg::ARCR_SEL_RUN) begin
            next_q.down_counter = q.reload_capture_register;
            next_q.st = arcr_pkg::ARCR_ST_COUNT;
          end else if (q.reload_source_select == arcr_pkg::ARCR_SEL_NONE) begin
            next_q.st = arcr_pkg::ARCR_ST_COUNT;
          end else begin
            next_q.st = arcr_pkg::ARCR_ST_ARMED; // wait for the selected edge
          end
        end
        arcr_pkg::ARCR_ST_COUNT: begin
          if (tick) begin
            if (q.down_counter == arcr_pkg::CNT_ZERO) begin
              ovf = 1'b1;
              next_q.down_counter = q.reload_enable ? q.reload_capture_register
                                                    : arcr_pkg::CNT_FULL;
            end else begin
              next_q.down_counter = q.down_counter - 16'h0001;
            end
          end
        end
        default: begin
          next_q.st = arcr_pkg::ARCR_ST_ARMED;
        end
      endcase
      // edge-triggered restarts override counting from the same cycle
      if (q.reload_enable && q.st != arcr_pkg::ARCR_ST_HOLD) begin
        if (q.reload_source_select == arcr_pkg::ARCR_SEL_A && acc_a) begin
          next_q.down_counter = q.reload_capture_register;
          next_q.st = arcr_pkg::ARCR_ST_COUNT;
        end
        if (q.reload_source_select == arcr_pkg::ARCR_SEL_B && ev_b) begin
          // reload even when the flags stop the capture
          next_q.down_counter = q.reload_capture_register;
          next_q.st = arcr_pkg::ARCR_ST_COUNT;
        end
      end
    end

    // overflow flag and pin; hardware set wins over a same-cycle clear
    if (ovf) begin
      next_q.overflow_flag = 1'b1;
    end
    if (q.overflow_output_mode) begin
      next_q.ovf_pin = q.ovf_pin ^ ovf;
    end else begin
      next_q.ovf_pin = ovf || (q.ovf_pin && next_q.overflow_flag);
    end

    // compare and zero events come from the mask logic outside
    if (match_event) begin
      next_q.match_flag = 1'b1;
    end
    if (masked_zero_event) begin
      next_q.masked_zero_flag = 1'b1;
    end

    // registered from next-state values, so the pin follows an enable write at the same edge
    next_q.irq = (next_q.input_a_event_flag && next_q.input_a_irq_enable)
              || (next_q.input_b_event_flag && next_q.input_b_irq_enable)
              || (next_q.overflow_flag && next_q.overflow_irq_enable)
              || (next_q.match_flag && next_q.match_irq_enable)
              || (next_q.masked_zero_flag && next_q.masked_zero_irq_enable);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; all-zero reset leaves the prescaler off
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from flip-flops
  assign wb_dat_o            = q.rdata;
  assign wb_ack_o            = q.ack;
  assign timer_irq           = q.irq;
  assign overflow_output_pin = q.ovf_pin;

endmodule

/* verilog/arcr_pkg.sv */
// Purpose: shared constants and types of the auto-reload timer capture/reload block
// Assumes: classic wishbone, 32-bit data, register index times four is the byte address
// Notes:   all widths of register fields are 8 bits, counter values 16 bits
package arcr_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CAPSTAT = 8'he1; // capture status/control
  localparam logic [7:0] IDX_BCTRL   = 8'he2; // input-b, match and zero bits
  localparam logic [7:0] IDX_RUNPSC  = 8'he8; // run/prescale control
  localparam logic [7:0] IDX_RELOAD  = 8'he9; // reload/capture register
  localparam logic [7:0] IDX_CAPTURE = 8'heb; // capture value register
  localparam logic [7:0] IDX_COUNTER = 8'hf0; // down counter readback

  // run/prescale control fields
  localparam int RP_PSC_HI  = 7;
  localparam int RP_PSC_LO  = 6;
  localparam int RP_RELOAD  = 5;
  localparam int RP_RUN     = 4;
  localparam int RP_OVF_IEN = 3;
  localparam int RP_OVF_FLG = 2;
  localparam int RP_OVF_MD  = 1;

  // capture status/control fields
  localparam int CS_A_ERR  = 6;
  localparam int CS_B_ERR  = 5;
  localparam int CS_A_IEN  = 4;
  localparam int CS_A_FLG  = 3;
  localparam int CS_A_POL  = 2;
  localparam int CS_SEL_HI = 1;
  localparam int CS_SEL_LO = 0;

  // input-b / match / zero fields
  localparam int BC_B_POL = 7;
  localparam int BC_B_IEN = 6;
  localparam int BC_B_FLG = 5;
  localparam int BC_M_IEN = 4;
  localparam int BC_M_FLG = 3;
  localparam int BC_Z_IEN = 2;
  localparam int BC_Z_FLG = 1;

  // counter values and prescaler terminal counts
  localparam logic [15:0] CNT_FULL       = 16'hffff;
  localparam logic [15:0] CNT_ZERO       = 16'h0000;
  localparam logic [3:0]  PSC_DIV4_LAST  = 4'h3;
  localparam logic [3:0]  PSC_DIV16_LAST = 4'hf;

  typedef enum logic [1:0] {
    ARCR_SEL_RUN  = 2'b00,
    ARCR_SEL_A    = 2'b01,
    ARCR_SEL_B    = 2'b10,
    ARCR_SEL_NONE = 2'b11
  } arcr_sel_t;

  typedef enum logic [1:0] {
    ARCR_PSC_OFF   = 2'b00,
    ARCR_PSC_DIV1  = 2'b01,
    ARCR_PSC_DIV4  = 2'b10,
    ARCR_PSC_DIV16 = 2'b11
  } arcr_psc_t;

  typedef enum logic [1:0] {
    ARCR_ST_HOLD  = 2'b00,
    ARCR_ST_ARMED = 2'b01,
    ARCR_ST_COUNT = 2'b10
  } arcr_state_t;

endpackage

/* dv/arcr_timer_props.sv */
// Purpose: port-level checker of the capture/reload timer
// Assumes: sees only top ports; a write lands at the edge that takes it
// Notes:   enables and modes are shadowed from the writes seen on the bus
`timescale 1ns/1ps
module arcr_timer_props #(
  parameter int ADR_W = 10
) (
  input wire logic             sys_clk,
  input wire logic             reset,
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0]       wb_sel_i,
  input wire logic [31:0]      wb_dat_i,
  input wire logic [31:0]      wb_dat_o,
  input wire logic             wb_ack_o,
  input wire logic             capture_input_a,
  input wire logic             capture_input_b,
  input wire logic             match_event,
  input wire logic             masked_zero_event,
  input wire logic             timer_irq,
  input wire logic             overflow_output_pin
);
  logic [7:0] idx;
  logic       take;
  logic       wr;
  logic       clr;
  logic       mapped;
  logic [4:0] ien;
  logic       mode1;
  logic       stopped;
  logic       fresh;
  logic [1:0] calm;
  //////////////////////////////////////////////////////////////////////////////
  // decoded request; partial writes without lane 0 are ignored by the slave
  assign idx    = 8'(wb_adr_i[ADR_W-1:2]);
  assign take   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr     = take && wb_we_i && wb_sel_i[0];
  assign clr    = wr && idx == arcr_pkg::IDX_RUNPSC && !wb_dat_i[arcr_pkg::RP_OVF_FLG];
  assign mapped = idx inside {arcr_pkg::IDX_CAPSTAT, arcr_pkg::IDX_BCTRL, arcr_pkg::IDX_RUNPSC,
                              arcr_pkg::IDX_RELOAD, arcr_pkg::IDX_CAPTURE, arcr_pkg::IDX_COUNTER};
  // shadows; calm lags by design so a stop has settled before it is trusted
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ien     <= 5'h00;
      mode1   <= 1'b0;
      stopped <= 1'b1;
      fresh   <= 1'b1;
      calm    <= 2'h0;
    end else begin
      if (wr && idx == arcr_pkg::IDX_RUNPSC) begin
        ien[0]  <= wb_dat_i[arcr_pkg::RP_OVF_IEN];
        mode1   <= wb_dat_i[arcr_pkg::RP_OVF_MD];
        stopped <= wb_dat_i[7:6] == 2'h0 || !wb_dat_i[arcr_pkg::RP_RUN];
        fresh   <= 1'b0;
      end
      if (wr && idx == arcr_pkg::IDX_CAPSTAT) ien[1] <= wb_dat_i[arcr_pkg::CS_A_IEN];
      if (wr && idx == arcr_pkg::IDX_BCTRL) ien[4:2] <= {wb_dat_i[arcr_pkg::BC_B_IEN],
        wb_dat_i[arcr_pkg::BC_M_IEN], wb_dat_i[arcr_pkg::BC_Z_IEN]};
      calm <= (stopped && mode1) ? ((calm == 2'h3) ? calm : calm + 2'h1) : 2'h0;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence take_s;
    take;
  endsequence
  sequence rd_hole_s;
    take_s ##0 (!wb_we_i && !mapped);
  endsequence
  sequence rd_psc_s;
    take_s ##0 (!wb_we_i && fresh && idx == arcr_pkg::IDX_RUNPSC);
  endsequence
  ack_after_take_a: assert property (take_s |=> wb_ack_o)
    else $error("no ack one cycle after a request");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  dat_quiet_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside the ack cycle");
  hole_zero_a: assert property (rd_hole_s |=> wb_ack_o && wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  psc_reset_a: assert property (rd_psc_s |=> wb_dat_o[7:6] == 2'h0)
    else $error("prescale not off after reset");
  irq_masked_a: assert property (ien == 5'h0 && $past(ien) == 5'h0 |-> !timer_irq)
    else $error("interrupt with all enables off");
  ovf_clear_a: assert property ($fell(overflow_output_pin) && !mode1 && !$past(mode1)
    && !$past(mode1, 2) |-> $past(clr))
    else $error("overflow pin fell without a flag clear");
  stopped_pin_a: assert property (calm == 2'h3 |-> $stable(overflow_output_pin))
    else $error("overflow pin moved while stopped");
endmodule

/* dv/arcr_pin_model.sv */
// Purpose: far-side source of the two capture pins
// Assumes: pins are push-pull levels, changed just after a clock edge
// Notes:   levels are held at least three cycles so the synchroniser sees them
`timescale 1ns/1ps
module arcr_pin_model (
  input  wire logic sys_clk,
  output logic      pin_a,
  output logic      pin_b
);
  // both pins idle low
  initial begin
    pin_a = 1'b0;
    pin_b = 1'b0;
  end
  // move one pin; short holds would be lost in the sync stages, so clamp them
  task automatic drive(input logic on_b, input logic lvl, input int hold);
    @(posedge sys_clk);
    if (on_b) pin_b <= lvl;
    else pin_a <= lvl;
    repeat ((hold < 3) ? 3 : hold) @(posedge sys_clk);
  endtask
  // move both pins at one edge, so two events meet in one cycle
  task automatic both(input logic lvl_a, input logic lvl_b, input int hold);
    @(posedge sys_clk);
    pin_a <= lvl_a;
    pin_b <= lvl_b;
    repeat ((hold < 3) ? 3 : hold) @(posedge sys_clk);
  endtask
  // inactive level first, so the caller always ends on one active edge
  task automatic pulse(input logic on_b, input logic rising, input int hold);
    drive(on_b, !rising, hold);
    drive(on_b, rising, hold);
  endtask
endmodule

/* dv/tb_autoreload_timer_capture_reload.sv */
// Purpose: self-checking bench of the capture/reload timer
// Assumes: write effects land at the edge that raises ack; pin effects within 5 cycles
// Notes:   counter figures are bounded windows since bus timing adds slack
`timescale 1ns/1ps
`define CHK(got, exp) begin \
  checks_done++; \
  if ((got) !== (exp)) begin \
    errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); \
  end \
end
module tb_autoreload_timer_capture_reload;
  logic        sys_clk           = 1'b0;
  logic        reset             = 1'b1;
  logic        wb_cyc_i          = 1'b0;
  logic        wb_stb_i          = 1'b0;
  logic        wb_we_i           = 1'b0;
  logic [9:0]  wb_adr_i          = 10'h000;
  logic [3:0]  wb_sel_i          = 4'h3;
  logic [31:0] wb_dat_i          = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        capture_input_a;
  logic        capture_input_b;
  logic        match_event       = 1'b0;
  logic        masked_zero_event = 1'b0;
  logic        timer_irq;
  logic        overflow_output_pin;
  int          errors            = 0;
  int          checks_done       = 0;
  logic [15:0] seed              = 16'hd93e;
  logic [15:0] v;
  logic [15:0] c0;
  logic [15:0] r;
  int          n;
  //////////////////////////////////////////////////////////////////////////////
  // 40 mhz clock
  always #12.5 sys_clk = ~sys_clk;
  arcr_timer #(.ADR_W(10)) uut (.sys_clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .capture_input_a, .capture_input_b,
    .match_event, .masked_zero_event, .timer_irq, .overflow_output_pin);
  arcr_pin_model pins (.sys_clk, .pin_a(capture_input_a), .pin_b(capture_input_b));
  //////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  function automatic int hold();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return 3 + int'(seed[2:0]);
  endfunction
  // one classic cycle; the wait is bounded since a dead slave must not hang the run
  task automatic bus(input logic we, input logic [7:0] idx, input logic [15:0] wd,
                     output logic [15:0] rd);
    int k;
    k = 0;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {16'h0000, wd};
    do begin
      @(posedge sys_clk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 50);
    if (k >= 50) begin
      errors++;
      tally_and_finish();
    end
    rd = wb_dat_o[15:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [15:0] d);
    logic [15:0] x;
    bus(1'b1, idx, d, x);
  endtask
  task automatic rx(input logic [7:0] idx, input logic [15:0] e);
    logic [15:0] x;
    bus(1'b0, idx, 16'h0, x);
    `CHK(x, e)
  endtask
  // count cycles until the overflow pin changes
  task automatic wait_toggle(output int cnt);
    logic p;
    p = overflow_output_pin;
    cnt = 0;
    do begin
      @(posedge sys_clk);
      cnt++;
    end while (overflow_output_pin === p && cnt < 4000);
    if (cnt >= 4000) begin
      errors++;
      tally_and_finish();
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // main sequence: reset map, restart modes, free run, interrupts, prescaler
  initial begin
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    foreach (seed[i]) if (i < 7) rx(i == 6 ? 8'h10 : 8'he0 + 8'(i), 16'h0);
    rx(8'he8, 16'h0);
    wr(8'he8, 16'h0004);
    rx(8'he8, 16'h0);
    wr(8'he8, 16'h0060);
    wr(8'he9, 16'h8000);
    rx(8'he9, 16'h8000);
    wr(8'he1, 16'h0006);
    wr(8'he2, 16'h0080);
    wr(8'he8, 16'h0070);
    pins.pulse(1'b1, 1'b1, hold());
    rx(8'heb, 16'h0);
    rx(8'he2, 16'h00a0);
    bus(1'b0, 8'hf0, 16'h0, c0);
    `CHK(c0 > 16'h7f00 && c0 < 16'h8000, 1'b1)
    pins.pulse(1'b0, 1'b1, hold());
    bus(1'b0, 8'hf0, 16'h0, v);
    `CHK(v < c0, 1'b1)
    rx(8'he1, 16'h000e);
    pins.pulse(1'b1, 1'b1, hold());
    rx(8'he1, 16'h002e);
    rx(8'heb, 16'h0);
    wr(8'he1, 16'h0006);
    rx(8'he1, 16'h0006);
    pins.pulse(1'b1, 1'b1, hold());
    rx(8'heb, 16'h0);
    wr(8'he1, 16'h0006);
    wr(8'he2, 16'h0080);
    pins.pulse(1'b1, 1'b1, hold());
    bus(1'b0, 8'heb, 16'h0, v);
    `CHK(v > 16'h7f00 && v < 16'h8000, 1'b1)
    wr(8'he8, 16'h0060);
    rx(8'hf0, 16'h0);
    wr(8'he1, 16'h0005);
    wr(8'he2, 16'h0000);
    wr(8'he8, 16'h0070);
    rx(8'hf0, 16'h0);
    pins.pulse(1'b0, 1'b1, hold());
    bus(1'b0, 8'hf0, 16'h0, v);
    `CHK(v > 16'h7f00 && v < 16'h8000, 1'b1)
    rx(8'he1, 16'h000d);
    pins.both(1'b0, 1'b1, hold());
    pins.both(1'b1, 1'b0, hold());
    bus(1'b0, 8'heb, 16'h0, v);
    `CHK(v > 16'h7e00 && v < 16'h8000, 1'b1)
    rx(8'he1, 16'h004d);
    wr(8'he8, 16'h0060);
    wr(8'he1, 16'h0000);
    wr(8'he2, 16'h0000);
    wr(8'he8, 16'h0070);
    bus(1'b0, 8'hf0, 16'h0, v);
    `CHK(v > 16'h7f00 && v < 16'h8001, 1'b1)
    pins.pulse(1'b1, 1'b0, hold());
    rx(8'he2, 16'h0020);
    wr(8'he8, 16'h0000);
    wr(8'he1, 16'h0004);
    wr(8'he2, 16'h0000);
    wr(8'he8, 16'h0050);
    repeat (4) @(posedge sys_clk);
    rx(8'he8, 16'h0054);
    `CHK(overflow_output_pin, 1'b1)
    bus(1'b0, 8'hf0, 16'h0, c0);
    `CHK(c0 > 16'hff00, 1'b1)
    pins.pulse(1'b0, 1'b1, hold());
    rx(8'he1, 16'h000c);
    bus(1'b0, 8'he9, 16'h0, v);
    `CHK(v < c0 && v > 16'hfe00, 1'b1)
    pins.pulse(1'b0, 1'b1, hold());
    rx(8'he1, 16'h004c);
    rx(8'he9, v);
    pins.pulse(1'b1, 1'b0, hold());
    bus(1'b0, 8'heb, 16'h0, v);
    pins.pulse(1'b1, 1'b0, hold());
    rx(8'heb, v);
    rx(8'he1, 16'h006c);
    `CHK(timer_irq, 1'b0)
    wr(8'he8, 16'h005c);
    repeat (2) @(posedge sys_clk);
    `CHK(timer_irq, 1'b1)
    wr(8'he8, 16'h0050);
    repeat (3) @(posedge sys_clk);
    `CHK(overflow_output_pin, 1'b0)
    @(posedge sys_clk);
    match_event <= 1'b1;
    masked_zero_event <= 1'b1;
    @(posedge sys_clk);
    match_event <= 1'b0;
    masked_zero_event <= 1'b0;
    rx(8'he2, 16'h002a);
    wr(8'he2, 16'h003e);
    repeat (2) @(posedge sys_clk);
    `CHK(timer_irq, 1'b1)
    for (int p = 1; p < 4; p++) begin
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      r = 16'(4 + seed[3:0]);
      wr(8'he8, 16'h0020);
      wr(8'he9, r);
      wr(8'he1, 16'h0003);
      wr(8'he8, {8'h00, 2'(p), 6'h20});
      wr(8'he8, {8'h00, 2'(p), 6'h32});
      wait_toggle(n);
      wait_toggle(n);
      wait_toggle(n);
      `CHK(n, (int'(r) + 1) << (2 * (p - 1)))
    end
    wr(8'he8, 16'h0012);
    bus(1'b0, 8'hf0, 16'h0, v);
    repeat (10) @(posedge sys_clk);
    rx(8'hf0, v);
    tally_and_finish();
  end
endmodule
bind arcr_timer arcr_timer_props #(.ADR_W(ADR_W)) u_props (.sys_clk, .reset, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .capture_input_a,
  .capture_input_b, .match_event, .masked_zero_event, .timer_irq, .overflow_output_pin);
